// >>> hed_error_correction_unit.sv
/*
  Error correction unit between processor data bus and DRAM: generates
  check bits on writes, checks, flags and corrects on reads, and turns
  refresh passes into scrub write-backs.
  Assumes the memory controller issues one request per enabled cycle and
  returns stored data with its check bits in the same cycle as the request.
*/
`timescale 1ns/1ps
module hed_error_correction_unit
  import hed_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  input  wire logic [1:0]        req_mode,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic [CHK_W-1:0]  mem_rcheck,
  output logic                   rsp_valid_r,
  output logic      [DATA_W-1:0] rsp_data_r,
  output logic      [CHK_W-1:0]  rsp_check_r,
  output logic      [CHK_W-1:0]  syndrome_r,
  output logic                   single_err_r,
  output logic                   multi_err_r,
  output logic      [IDX_W-1:0]  err_index_r,
  output logic                   err_in_check_r,
  output logic                   wb_valid_r,
  output logic                   cpu_wait_r
);

  typedef enum logic {ST_RUN, ST_HOLD} hed_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Check and decode

  logic             fire;
  logic             is_write;
  logic             is_read;
  logic [DATA_W-1:0] gen_in;
  logic [CHK_W-1:0] gen_check;
  logic [CHK_W-1:0] syn_now;
  hed_cls_t         cls_now;
  logic [IDX_W-1:0] idx_now;
  logic [2:0]       cidx_now;
  logic [DATA_W-1:0] fixed_data;
  logic [CHK_W-1:0] fixed_check;

  assign fire     = clk_en && req_valid;
  assign is_write = (req_mode == MODE_WRITE);
  assign is_read  = !is_write;
  // Sharing one generator between write and read keeps a single matrix copy
  assign gen_in   = is_write ? req_wdata : mem_rdata;

  hed_chkgen u_chkgen (
    .data  (gen_in),
    .check (gen_check)
  );

  // Stored check bits come back from memory beside the data
  assign syn_now = ~(gen_check ^ mem_rcheck);

  hed_syndec u_syndec (
    .syndrome       (syn_now),
    .cls            (cls_now),
    .data_bit_index (idx_now),
    .check_index    (cidx_now)
  );

  always_comb begin
    fixed_data  = mem_rdata;
    fixed_check = gen_check;
    if (cls_now == CLS_DATA) begin
      fixed_data  = mem_rdata ^ (DATA_W'(1) << idx_now);
      fixed_check = gen_check ^ ~syn_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response registers

  hed_state_t       state_r;
  hed_state_t       state_nxt;
  logic             rsp_valid_nxt;
  logic [DATA_W-1:0] rsp_data_nxt;
  logic [CHK_W-1:0] rsp_check_nxt;
  logic [CHK_W-1:0] syndrome_nxt;
  logic             single_err_nxt;
  logic             multi_err_nxt;
  logic [IDX_W-1:0] err_index_nxt;
  logic             err_in_check_nxt;
  logic             wb_valid_nxt;
  logic             cpu_wait_nxt;
  logic             any_err;
  logic             fixable;

  assign any_err = (cls_now != CLS_NONE);
  assign fixable = (cls_now == CLS_NONE) || (cls_now == CLS_DATA) ||
                   (cls_now == CLS_CHECK);

  always_comb begin
    state_nxt        = state_r;
    rsp_valid_nxt    = 1'b0;
    rsp_data_nxt     = rsp_data_r;
    rsp_check_nxt    = rsp_check_r;
    syndrome_nxt     = syndrome_r;
    single_err_nxt   = single_err_r;
    multi_err_nxt    = multi_err_r;
    err_index_nxt    = err_index_r;
    err_in_check_nxt = err_in_check_r;
    wb_valid_nxt     = 1'b0;
    cpu_wait_nxt     = cpu_wait_r;
    if (fire) begin
      rsp_valid_nxt = 1'b1;
      if (is_write) begin
        rsp_data_nxt     = req_wdata;
        rsp_check_nxt    = gen_check;
        syndrome_nxt     = SYN_CLEAN;
        single_err_nxt   = 1'b0;
        multi_err_nxt    = 1'b0;
        err_index_nxt    = IDX_RST;
        err_in_check_nxt = 1'b0;
      end else begin
        syndrome_nxt     = syn_now;
        // Single: data or check bit; unmatched odd codes raise both flags
        single_err_nxt   = (cls_now == CLS_DATA) || (cls_now == CLS_CHECK) ||
                           (cls_now == CLS_MULTI);
        multi_err_nxt    = (cls_now == CLS_DOUBLE) ||
                           (cls_now == CLS_MULTI);
        err_index_nxt    = (cls_now == CLS_CHECK) ? {2'b00, cidx_now} : idx_now;
        err_in_check_nxt = (cls_now == CLS_CHECK);
        case (req_mode)
          MODE_DETECT: begin
            // Raw data reaches the processor at once; it waits on an error
            rsp_data_nxt  = mem_rdata;
            rsp_check_nxt = mem_rcheck;
            if (any_err) begin
              state_nxt    = ST_HOLD;
              cpu_wait_nxt = 1'b1;
            end
          end
          MODE_CORRECT: begin
            rsp_data_nxt  = fixed_data;
            rsp_check_nxt = fixed_check;
            // Write back only when something was repaired
            wb_valid_nxt  = fixable && any_err;
          end
          default: begin
            rsp_data_nxt  = fixed_data;
            rsp_check_nxt = fixed_check;
            // A multibit word is left as is rather than made worse
            wb_valid_nxt  = fixable;
          end
        endcase
        if (state_r == ST_HOLD && req_mode != MODE_DETECT) begin
          state_nxt    = ST_RUN;
          cpu_wait_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r        <= ST_RUN;
      rsp_valid_r    <= 1'b0;
      rsp_data_r     <= '0;
      rsp_check_r    <= '0;
      syndrome_r     <= SYN_CLEAN;
      single_err_r   <= 1'b0;
      multi_err_r    <= 1'b0;
      err_index_r    <= IDX_RST;
      err_in_check_r <= 1'b0;
      wb_valid_r     <= 1'b0;
      cpu_wait_r     <= 1'b0;
    end else if (clk_en) begin
      state_r        <= state_nxt;
      rsp_valid_r    <= rsp_valid_nxt;
      rsp_data_r     <= rsp_data_nxt;
      rsp_check_r    <= rsp_check_nxt;
      syndrome_r     <= syndrome_nxt;
      single_err_r   <= single_err_nxt;
      multi_err_r    <= multi_err_nxt;
      err_index_r    <= err_index_nxt;
      err_in_check_r <= err_in_check_nxt;
      wb_valid_r     <= wb_valid_nxt;
      cpu_wait_r     <= cpu_wait_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_write_req;
    fire && is_write;
  endsequence

  sequence s_read_code(logic [CHK_W-1:0] code);
    fire && is_read && (syn_now == code);
  endsequence

  property p_names_bit(logic [CHK_W-1:0] code, logic [IDX_W-1:0] idx);
    s_read_code(code) |=> rsp_valid_r && single_err_r && !multi_err_r &&
                          (err_index_r == idx) && !err_in_check_r;
  endproperty

  a_write_check_gen: assert property (s_write_req |=>
    rsp_valid_r && (rsp_check_r == hed_parity($past(req_wdata))))
    else $error("write check bits wrong");

  a_zero_word_polarity: assert property (
    s_write_req ##0 (req_wdata == '0) |=> (rsp_check_r == CHK_INV))
    else $error("check bit polarity wrong for zero word");

  a_clean_read_flags: assert property (
    fire && is_read && (mem_rcheck == hed_parity(mem_rdata)) |=>
      (syndrome_r == SYN_CLEAN) && !single_err_r && !multi_err_r)
    else $error("clean word flagged");

  a_corrected_consistent: assert property (
    fire && (req_mode == MODE_CORRECT) && (cls_now != CLS_DOUBLE) &&
    (cls_now != CLS_MULTI) |=> hed_parity(rsp_data_r) == rsp_check_r)
    else $error("corrected word does not check");

  a_detect_passthru: assert property (
    fire && (req_mode == MODE_DETECT) && (syn_now != SYN_CLEAN) |=>
      (rsp_data_r == $past(mem_rdata)) && cpu_wait_r ##1
      (cpu_wait_r || $past(fire && req_mode != MODE_DETECT)))
    else $error("detect-only data or wait wrong");

  a_wait_release: assert property (
    cpu_wait_r && !(fire && req_mode != MODE_DETECT) |=> cpu_wait_r)
    else $error("processor wait dropped early");

  a_unc_both_flags: assert property (
    s_read_code(SYN_ZERO) |=> single_err_r && multi_err_r)
    else $error("multibit code not flagged on both");

  a_scrub_writeback: assert property (
    fire && (req_mode == MODE_SCRUB) && (hed_weight(~syn_now) < 3'd2) |=>
      wb_valid_r ##1 (!wb_valid_r || $past(fire) || !$past(clk_en)))
    else $error("scrub write-back missing");

  a_db31_code: assert property (p_names_bit(7'h0A, 5'h1F))
    else $error("bit 31 code misdecoded");

  a_db30_code: assert property (p_names_bit(7'h0F, 5'h1E))
    else $error("bit 30 code misdecoded");

  a_db28_code: assert property (p_names_bit(7'h14, 5'h1C))
    else $error("bit 28 code misdecoded");

  a_db24_code: assert property (p_names_bit(7'h1D, 5'h18))
    else $error("bit 24 code misdecoded");

  sequence s_check_bit_err;
    fire && is_read && (hed_weight(~syn_now) == 3'h1);
  endsequence

  a_check_bit_flag: assert property (s_check_bit_err |=>
    single_err_r && !multi_err_r && err_in_check_r)
    else $error("check bit error misflagged");

  a_double_flags: assert property (
    fire && is_read && (hed_weight(~syn_now) inside {3'h2, 3'h4, 3'h6}) |=>
      !single_err_r && multi_err_r)
    else $error("double error misflagged");

  a_data_bit_inverted: assert property (
    fire && (req_mode == MODE_CORRECT) && (cls_now == CLS_DATA) |=>
      (hed_parity(rsp_data_r) == $past(mem_rcheck)) &&
      ($countones(rsp_data_r ^ $past(mem_rdata)) == 1))
    else $error("single data bit not inverted");

  a_correct_writeback: assert property (
    fire && (req_mode == MODE_CORRECT) &&
    ((cls_now == CLS_DATA) || (cls_now == CLS_CHECK)) |=> wb_valid_r)
    else $error("corrected word not written back");

  a_detect_raw_check: assert property (
    fire && (req_mode == MODE_DETECT) |=>
      !wb_valid_r && (rsp_check_r == $past(mem_rcheck)))
    else $error("detect-only read altered word");

  a_scrub_skips_double: assert property (
    fire && (req_mode == MODE_SCRUB) &&
    (hed_weight(~syn_now) inside {3'h2, 3'h4, 3'h6}) |=> !wb_valid_r)
    else $error("double error word written back");

endmodule : hed_error_correction_unit

// >>> hed_pkg.sv
/*
  Shared constants, types and functions of the 32-bit single-correct,
  double-detect Hamming unit: modes, error classes, the parity matrix.
  Assumes nothing of its surroundings; imported whole by every module.
*/
package hed_pkg;

  localparam int DATA_W = 32;
  localparam int CHK_W  = 7;
  localparam int IDX_W  = 5;

  // Request modes presented with each access
  localparam logic [1:0] MODE_WRITE   = 2'h0;
  localparam logic [1:0] MODE_DETECT  = 2'h1;
  localparam logic [1:0] MODE_CORRECT = 2'h2;
  localparam logic [1:0] MODE_SCRUB   = 2'h3;

  // Check bit 0 high on an odd count, bits 1-2 odd parity, bits 3-6 even parity
  localparam logic [CHK_W-1:0] CHK_INV = 7'h06;

  // Syndrome is the complement of the difference, so a clean word reads all ones
  localparam logic [CHK_W-1:0] SYN_CLEAN = 7'h7F;
  localparam logic [CHK_W-1:0] SYN_ZERO  = 7'h00;

  // Column of the parity matrix for each data bit, bit 31 first
  // Columns 31, 30, 28 and 24 fix the given codes
  localparam logic [DATA_W-1:0][CHK_W-1:0] COL_TAB = {
    7'h75, 7'h70, 7'h52, 7'h6B, 7'h51, 7'h4C, 7'h4A, 7'h62,
    7'h49, 7'h46, 7'h45, 7'h43, 7'h38, 7'h34, 7'h32, 7'h31,
    7'h2C, 7'h2A, 7'h29, 7'h26, 7'h25, 7'h23, 7'h1C, 7'h1A,
    7'h19, 7'h16, 7'h15, 7'h13, 7'h0E, 7'h0D, 7'h0B, 7'h07
  };

  localparam logic [IDX_W-1:0] IDX_RST = 5'h00;
  localparam logic [2:0]       CIDX_RST = 3'h0;

  typedef enum logic [2:0] {
    CLS_NONE,
    CLS_DATA,
    CLS_CHECK,
    CLS_DOUBLE,
    CLS_MULTI
  } hed_cls_t;

  // Seven check bits of a data word, each a parity over its matrix row
  function automatic logic [CHK_W-1:0] hed_parity(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] p;
    p = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (d[i]) begin
        p = p ^ COL_TAB[i];
      end
    end
    return p ^ CHK_INV;
  endfunction : hed_parity

  function automatic logic [2:0] hed_weight(input logic [CHK_W-1:0] v);
    logic [2:0] w;
    w = '0;
    for (int i = 0; i < CHK_W; i++) begin
      w = w + {2'b00, v[i]};
    end
    return w;
  endfunction : hed_weight

endpackage : hed_pkg

// >>> hed_chkgen.sv
/*
  Check-bit generator: seven parity bits over a 32-bit word.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module hed_chkgen
  import hed_pkg::*;
(
  input  wire logic [DATA_W-1:0] data,
  output logic      [CHK_W-1:0]  check
);

  always_comb begin
    check = hed_parity(data);
  end

endmodule : hed_chkgen

// >>> hed_syndec.sv
/*
  Syndrome decoder: classifies a 7-bit syndrome and names the bad bit.
  Combinational; syndrome uses the all-ones-is-clean convention.
*/
`timescale 1ns/1ps
module hed_syndec
  import hed_pkg::*;
(
  input  wire logic [CHK_W-1:0] syndrome,
  output hed_cls_t              cls,
  output logic      [IDX_W-1:0] data_bit_index,
  output logic      [2:0]       check_index
);

  logic [CHK_W-1:0] diff;
  logic             hit;
  logic [2:0]       wt;

  always_comb begin
    diff           = ~syndrome;
    wt             = hed_weight(diff);
    hit            = 1'b0;
    data_bit_index = IDX_RST;
    check_index    = CIDX_RST;
    for (int i = 0; i < DATA_W; i++) begin
      if (diff == COL_TAB[i]) begin
        hit            = 1'b1;
        data_bit_index = IDX_W'(i);
      end
    end
    for (int k = 0; k < CHK_W; k++) begin
      if (diff == CHK_W'(1 << k)) begin
        check_index = 3'(k);
      end
    end
    if (diff == '0) begin
      cls = CLS_NONE;
    end else if (hit) begin
      cls = CLS_DATA;
    end else if (wt == 3'h1) begin
      cls = CLS_CHECK;
    end else if (!wt[0]) begin
      cls = CLS_DOUBLE;
    end else begin
      cls = CLS_MULTI;
    end
  end

endmodule : hed_syndec

// >>> hed_mem_model.sv
/*
  Memory model at the far side of the error correction unit: keeps each word
  with its check bits and returns both in the request cycle.
  Assumes the bench injects faults only through flip_d and flip_c on a write.
*/
`timescale 1ns/1ps
module hed_mem_model
  import hed_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  input  wire logic [1:0]        req_mode,
  input  wire logic [3:0]        addr,
  input  wire logic [DATA_W-1:0] flip_d,
  input  wire logic [CHK_W-1:0]  flip_c,
  input  wire logic              rsp_valid_r,
  input  wire logic              wb_valid_r,
  input  wire logic [DATA_W-1:0] rsp_data_r,
  input  wire logic [CHK_W-1:0]  rsp_check_r,
  output logic      [DATA_W-1:0] mem_rdata,
  output logic      [CHK_W-1:0]  mem_rcheck
);
  logic [DATA_W+CHK_W-1:0] mem_r [16];
  logic [3:0]              wr_addr_r;
  logic                    wr_pend_r;
  logic [DATA_W-1:0]       fd_r;
  logic [CHK_W-1:0]        fc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Word and check bits share one entry, so they always come back together
  assign mem_rdata  = mem_r[addr][DATA_W+CHK_W-1:CHK_W];
  assign mem_rcheck = mem_r[addr][CHK_W-1:0];

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_r[i] = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Faults are stored, not added on read, so they persist until a correct or scrub read writes the word back
  always @(posedge clk) begin
    if (clk_en) begin
      if ((rsp_valid_r && wr_pend_r) || wb_valid_r) begin
        mem_r[wr_addr_r] <= {rsp_data_r ^ fd_r, rsp_check_r ^ fc_r};
      end
      if (req_valid) begin
        wr_addr_r <= addr;
        wr_pend_r <= (req_mode == MODE_WRITE);
        fd_r      <= flip_d;
        fc_r      <= flip_c;
      end
    end
  end
endmodule : hed_mem_model

// >>> hed_error_correction_unit_tb.sv
/*
  Self-checking bench of the error correction unit with its memory model.
  Assumes one-cycle answers and stored faults injected on writes.
*/
`timescale 1ns/1ps
module hed_error_correction_unit_tb
  import hed_pkg::*;
;
  logic              clk, reset_n, clk_en, req_valid, rsp_valid_r, single_err_r;
  logic              multi_err_r, err_in_check_r, wb_valid_r, cpu_wait_r;
  logic [1:0]        req_mode;
  logic [3:0]        addr;
  logic [DATA_W-1:0] req_wdata, mem_rdata, rsp_data_r, flip_d, pat;
  logic [CHK_W-1:0]  mem_rcheck, rsp_check_r, syndrome_r, flip_c;
  logic [IDX_W-1:0]  err_index_r;
  int                n_errors, num_checks;

  hed_error_correction_unit uut (.clk, .reset_n, .clk_en, .req_valid, .req_mode, .req_wdata, .mem_rdata,
    .mem_rcheck, .rsp_valid_r, .rsp_data_r, .rsp_check_r, .syndrome_r, .single_err_r,
    .multi_err_r, .err_index_r, .err_in_check_r, .wb_valid_r, .cpu_wait_r);
  hed_mem_model mem (.clk, .clk_en, .req_valid, .req_mode, .addr, .flip_d, .flip_c,
    .rsp_valid_r, .wb_valid_r, .rsp_data_r, .rsp_check_r, .mem_rdata, .mem_rcheck);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic cmp_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_vec(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : cmp_vec

  function automatic logic [CHK_W-1:0] exp_chk(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] p;
    p = CHK_INV;
    for (int i = 0; i < DATA_W; i++) begin
      if (d[i]) p = p ^ COL_TAB[i];
    end
    return p;
  endfunction : exp_chk

  function automatic logic [CHK_W-1:0] exp_syn(input int i);
    case (i)
      31: return 7'h0A;
      30: return 7'h0F;
      28: return 7'h14;
      24: return 7'h1D;
      default: return ~COL_TAB[i];
    endcase
  endfunction : exp_syn

  // One request, then wait a bounded time for its answer
  task automatic req(input logic [1:0] m, input logic [3:0] a, input logic [31:0] w,
                     input logic [31:0] fd, input logic [6:0] fc);
    int k;
    @(posedge clk);
    #1;
    {req_valid, req_mode, addr, req_wdata, flip_d, flip_c} = {1'b1, m, a, w, fd, fc};
    @(posedge clk);
    #1;
    {req_valid, flip_d, flip_c} = '0;
    k = 0;
    while (rsp_valid_r !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (rsp_valid_r !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask : req

  task automatic chk_rd(input logic [31:0] d, input logic [6:0] s, input logic se,
                        input logic me);
    cmp_vec("rsp_data_r", d, rsp_data_r);
    cmp_vec("syndrome_r", s, syndrome_r);
    cmp_bit("single_err_r", se, single_err_r);
    cmp_bit("multi_err_r", me, multi_err_r);
  endtask : chk_rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write;
    req(MODE_WRITE, 0, 32'h0, 0, 0);
    cmp_vec("rsp_check_r", 7'h06, rsp_check_r);
    for (int i = 0; i < 4; i++) begin
      pat = 32'hF0E1_D2C3 ^ (32'(i) * 32'h3579_BDF1);
      req(MODE_WRITE, 1, pat, 0, 0);
      cmp_vec("rsp_check_r", exp_chk(pat), rsp_check_r);
      cmp_bit("single_err_r", 1'b0, single_err_r);
    end
  endtask : t_write

  task automatic t_single;
    for (int i = 0; i < DATA_W; i++) begin
      pat = 32'h3C96_A50F ^ (32'(i) * 32'h0101_0101);
      req(MODE_WRITE, 2, pat, 32'h1 << i, 0);
      req(MODE_CORRECT, 2, 0, 0, 0);
      chk_rd(pat, exp_syn(i), 1'b1, 1'b0);
      cmp_vec("err_index_r", i, err_index_r);
      cmp_bit("wb_valid_r", 1'b1, wb_valid_r);
      cmp_vec("rsp_check_r", exp_chk(pat), rsp_check_r);
    end
    req(MODE_CORRECT, 2, 0, 0, 0);
    chk_rd(pat, SYN_CLEAN, 1'b0, 1'b0);
    cmp_bit("wb_valid_r", 1'b0, wb_valid_r);
    for (int k = 0; k < CHK_W; k++) begin
      req(MODE_WRITE, 6, pat, 0, 7'h01 << k);
      req(MODE_CORRECT, 6, 0, 0, 0);
      chk_rd(pat, SYN_CLEAN ^ (7'h01 << k), 1'b1, 1'b0);
      cmp_vec("err_index_r", k, err_index_r);
      cmp_bit("err_in_check_r", 1'b1, err_in_check_r);
    end
  endtask : t_single

  task automatic t_multi;
    req(MODE_WRITE, 7, pat, 32'h3, 0);
    req(MODE_CORRECT, 7, 0, 0, 0);
    cmp_vec("syndrome_r", CHK_W'(~(COL_TAB[0] ^ COL_TAB[1])), syndrome_r);
    cmp_bit("multi_err_r", 1'b1, multi_err_r);
    cmp_bit("wb_valid_r", 1'b0, wb_valid_r);
    req(MODE_SCRUB, 7, 0, 0, 0);
    cmp_bit("wb_valid_r", 1'b0, wb_valid_r);
    req(MODE_WRITE, 8, pat, 32'h10, 7'h01);
    req(MODE_CORRECT, 8, 0, 0, 0);
    cmp_vec("syndrome_r", CHK_W'(~(COL_TAB[4] ^ 7'h01)), syndrome_r);
    cmp_bit("multi_err_r", 1'b1, multi_err_r);
    req(MODE_WRITE, 8, pat, 0, 7'h7F);
    req(MODE_CORRECT, 8, 0, 0, 0);
    chk_rd(pat, SYN_ZERO, 1'b1, 1'b1);
  endtask : t_multi

  task automatic t_detect;
    req(MODE_WRITE, 9, pat, 32'h200, 0);
    req(MODE_DETECT, 9, 0, 0, 0);
    chk_rd(pat ^ 32'h200, ~COL_TAB[9], 1'b1, 1'b0);
    cmp_bit("cpu_wait_r", 1'b1, cpu_wait_r);
    req(MODE_DETECT, 9, 0, 0, 0);
    cmp_bit("cpu_wait_r", 1'b1, cpu_wait_r);
    req(MODE_CORRECT, 9, 0, 0, 0);
    cmp_vec("rsp_data_r", pat, rsp_data_r);
    cmp_bit("cpu_wait_r", 1'b0, cpu_wait_r);
  endtask : t_detect

  // Data-bit and check-bit faults are both scrubbed and written back
  task automatic t_scrub;
    req(MODE_WRITE, 10, pat, 32'h2_0000, 0);
    req(MODE_SCRUB, 10, 0, 0, 0);
    cmp_bit("wb_valid_r", 1'b1, wb_valid_r);
    cmp_vec("rsp_data_r", pat, rsp_data_r);
    req(MODE_CORRECT, 10, 0, 0, 0);
    chk_rd(pat, SYN_CLEAN, 1'b0, 1'b0);
    req(MODE_WRITE, 11, pat, 0, 7'h20);
    req(MODE_SCRUB, 11, 0, 0, 0);
    cmp_bit("wb_valid_r", 1'b1, wb_valid_r);
    cmp_vec("rsp_check_r", exp_chk(pat), rsp_check_r);
    req(MODE_CORRECT, 11, 0, 0, 0);
    chk_rd(pat, SYN_CLEAN, 1'b0, 1'b0);
  endtask : t_scrub

  // A frozen clock enable must hold a request off until it rises
  task automatic t_stall;
    @(posedge clk);
    #1;
    {clk_en, req_valid, req_mode, addr, req_wdata} = {1'b0, 1'b1, MODE_WRITE, 4'h5, pat};
    repeat (2) @(posedge clk);
    #1;
    cmp_bit("rsp_valid_r", 1'b0, rsp_valid_r);
    clk_en = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    cmp_bit("rsp_valid_r", 1'b1, rsp_valid_r);
    cmp_vec("rsp_check_r", exp_chk(pat), rsp_check_r);
  endtask : t_stall

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk_en, reset_n, req_valid, req_mode, addr, req_wdata, flip_d, flip_c} = {1'b1, 79'h0};
    n_errors = 0;
    num_checks = 0;
    pat = 32'h0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk_rd(32'h0, SYN_CLEAN, 1'b0, 1'b0);
    cmp_bit("cpu_wait_r", 1'b0, cpu_wait_r);
    t_write();
    t_single();
    t_multi();
    t_detect();
    t_scrub();
    t_stall();
    end_sim();
  end
endmodule : hed_error_correction_unit_tb
